// >>> acq_status.sv
// Acquisition status word with APB register access and error abort
//
// Notes on behaviour
// RULE1: Bit 11 reads 1 while an acquisition run is active, else 0.
// RULE2: Bit 10 sets on a transfer terminal-count pulse; marks that interrupt cause.
// RULE3: Terminal-count flag holds until software writes the terminal-count clear strobe.
// RULE4: Bit 9 sets when a result arrives while the FIFO is full.
// RULE5: FIFO overflow during a run ends the run at once.
// RULE6: Bit 8 sets when a conversion starts before the previous one finished.
// RULE7: Conversion overrun during a run ends the run at once.
// RULE8: Overflow and overrun flags hold until the conversion clear strobe is written.
// RULE9: Bits 7-6 return the gain code applied to the amplifier.
// RULE10: Dual mode alternates transfer channels; bit 5 shows 0 for channel 1, 1 for 2.
// RULE11: Without dual mode only transfer channel 1 is used.
// RULE12: Bit 4 shows upper mux enable; single-ended on only for channels 8-15.
// RULE13: Bit 3 shows lower mux enable; single-ended on only for channels 0-7.
// RULE14: Bits 2-0 hold low channel address; upper mux means address plus 8.
// RULE15: Differential mode selects address and address plus 8 together.
// RULE16: Differential mode keeps both muxes enabled, both enable bits read 1.
// RULE17: Status word is a 16-bit read-only register at offset 0.
// RULE18: Reading the status word changes nothing.
`timescale 1ns/100ps
`default_nettype none
module acq_status
   import acq_status_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic acq_start,
   input wire logic acq_count_done,
   input wire logic xfer_tc,
   input wire logic xfer_done,
   input wire logic conv_start,
   input wire logic conv_busy,
   input wire logic conv_result_valid,
   input wire logic fifo_full,
   output logic acq_active,
   output logic acq_abort,
   output logic xfer_count_done_flag,
   output logic xfer_channel_sel,
   output logic [1:0] gain_code,
   output logic upper_mux_on,
   output logic lower_mux_on,
   output logic [2:0] mux_addr_low,
   output logic irq
);
   typedef struct packed {
      acq_state_type acq;
      logic tc_flag;
      logic ovf_flag;
      logic ovr_flag;
      logic xfer_ch;
      logic [1:0] gain;
      logic dual;
      logic diff;
      logic [3:0] chan;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic [31:0] rdata;
      logic slverr;
      logic abort;
   } state_type;

   state_type s_reg;
   state_type s_next;
   mux_sel_if sel_bus ();

   logic setup;
   logic wr;
   logic ovf_evt;
   logic ovr_evt;
   logic tc_clr;
   logic conv_clr;
   logic [15:0] status_word;

   function automatic logic known_addr(input logic [ADDR_W-1:0] a);
      known_addr = (a == OFS_STATUS) || (a == OFS_CTRL) || (a == OFS_TC_CLEAR) ||
                   (a == OFS_CONV_CLEAR) || (a == OFS_IRQ_STATUS) || (a == OFS_IRQ_MASK);
   endfunction

   function automatic logic is_wr(input logic w, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      is_wr = w && (a == ofs);
   endfunction

   // Zero wait states: read data is captured in the setup cycle
   assign setup = psel && !penable;
   assign pready = psel && penable;
   assign wr = psel && penable && pwrite;
   assign ovf_evt = conv_result_valid && fifo_full; // RULE4
   assign ovr_evt = conv_start && conv_busy; // RULE6
   assign tc_clr = is_wr(wr, paddr, OFS_TC_CLEAR);
   assign conv_clr = is_wr(wr, paddr, OFS_CONV_CLEAR);

   always_comb begin
      status_word = 16'h0000;
      status_word[ST_ACQ_ACTIVE] = (s_reg.acq == ACQ_RUN); // RULE1
      status_word[ST_TC_FLAG] = s_reg.tc_flag; // RULE2
      status_word[ST_OVERFLOW] = s_reg.ovf_flag; // RULE4
      status_word[ST_OVERRUN] = s_reg.ovr_flag; // RULE6
      status_word[ST_GAIN_LSB +: 2] = s_reg.gain; // RULE9
      status_word[ST_XFER_CH] = s_reg.xfer_ch; // RULE10
      status_word[ST_UPPER_MUX] = sel_bus.upper_mux_on; // RULE12
      status_word[ST_LOWER_MUX] = sel_bus.lower_mux_on; // RULE13
      status_word[ST_ADDR_LSB +: 3] = sel_bus.mux_addr_low; // RULE14
   end

   always_comb begin
      s_next = s_reg;
      s_next.abort = 1'b0;
      // Acquisition run control; an error ends the run in the same cycle
      case (s_reg.acq)
         ACQ_IDLE: begin
            if (acq_start && !ovf_evt && !ovr_evt) begin
               s_next.acq = ACQ_RUN;
            end
         end
         ACQ_RUN: begin
            if (ovf_evt || ovr_evt) begin
               s_next.acq = ACQ_IDLE; // RULE5 RULE7
               s_next.abort = 1'b1; // RULE5 RULE7
            end else if (acq_count_done) begin
               s_next.acq = ACQ_IDLE;
            end
         end
         default: begin
            s_next.acq = ACQ_IDLE;
         end
      endcase
      // Flags: a hardware event in the clear cycle wins over the clear
      if (tc_clr) begin
         s_next.tc_flag = 1'b0; // RULE3
      end
      if (xfer_tc) begin
         s_next.tc_flag = 1'b1; // RULE2
      end
      if (conv_clr) begin
         s_next.ovf_flag = 1'b0; // RULE8
         s_next.ovr_flag = 1'b0; // RULE8
      end
      if (ovf_evt) begin
         s_next.ovf_flag = 1'b1; // RULE4
      end
      if (ovr_evt) begin
         s_next.ovr_flag = 1'b1; // RULE6
      end
      // Transfer channel
      if (!s_reg.dual) begin
         s_next.xfer_ch = 1'b0; // RULE11
      end else if (xfer_done) begin
         s_next.xfer_ch = ~s_reg.xfer_ch; // RULE10
      end
      // Register writes; the status word itself has no write path
      if (is_wr(wr, paddr, OFS_CTRL) && pstrb[0]) begin
         s_next.chan = pwdata[CT_CHAN_LSB +: 4];
         s_next.gain = pwdata[CT_GAIN_LSB +: 2]; // RULE9
         s_next.dual = pwdata[CT_DUAL];
         s_next.diff = pwdata[CT_DIFF];
      end
      if (is_wr(wr, paddr, OFS_IRQ_MASK) && pstrb[0]) begin
         s_next.irq_mask = pwdata[IRQ_W-1:0];
      end
      if (is_wr(wr, paddr, OFS_IRQ_STATUS) && pstrb[0]) begin
         s_next.irq_stat = s_reg.irq_stat & ~pwdata[IRQ_W-1:0];
      end
      if (xfer_tc) begin
         s_next.irq_stat[IRQ_TC] = 1'b1;
      end
      if (ovf_evt) begin
         s_next.irq_stat[IRQ_OVERFLOW] = 1'b1;
      end
      if (ovr_evt) begin
         s_next.irq_stat[IRQ_OVERRUN] = 1'b1;
      end
      if (s_reg.acq == ACQ_RUN && s_next.acq == ACQ_IDLE) begin
         s_next.irq_stat[IRQ_ACQ_END] = 1'b1;
      end
      // Reads have no side effects on any flag
      if (setup) begin
         s_next.rdata = RST_RDATA;
         s_next.slverr = !known_addr(paddr) || (pwrite && paddr == OFS_STATUS); // RULE17
         if (!pwrite) begin
            case (paddr)
               OFS_STATUS: s_next.rdata = {16'h0000, status_word}; // RULE17 RULE18
               OFS_CTRL: s_next.rdata = {24'h00_0000, s_reg.diff, s_reg.dual, s_reg.gain, s_reg.chan};
               OFS_IRQ_STATUS: s_next.rdata = {28'h000_0000, s_reg.irq_stat};
               OFS_IRQ_MASK: s_next.rdata = {28'h000_0000, s_reg.irq_mask};
               default: s_next.rdata = RST_RDATA;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '{acq: ACQ_IDLE, tc_flag: 1'b0, ovf_flag: 1'b0, ovr_flag: 1'b0, xfer_ch: 1'b0,
                    gain: RST_GAIN, dual: 1'b0, diff: 1'b0, chan: RST_CHAN, irq_stat: '0,
                    irq_mask: RST_IRQ_MASK, rdata: RST_RDATA, slverr: 1'b0, abort: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign sel_bus.chan = s_reg.chan;
   assign sel_bus.diff = s_reg.diff;

   mux_decode u_mux_decode (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .sel(sel_bus)
   );

   assign prdata = s_reg.rdata;
   assign pslverr = pready && s_reg.slverr;
   assign acq_active = (s_reg.acq == ACQ_RUN); // RULE1
   assign acq_abort = s_reg.abort;
   assign xfer_count_done_flag = s_reg.tc_flag;
   assign xfer_channel_sel = s_reg.xfer_ch;
   assign gain_code = s_reg.gain;
   assign upper_mux_on = sel_bus.upper_mux_on;
   assign lower_mux_on = sel_bus.lower_mux_on;
   assign mux_addr_low = sel_bus.mux_addr_low;
   // Level output; clears only when software clears or masks every pending cause
   assign irq = |(s_reg.irq_stat & s_reg.irq_mask);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence s_status_read;
      psel && !penable && !pwrite && paddr == OFS_STATUS;
   endsequence
   sequence s_flags_kept;
      $stable(s_reg.tc_flag) && $stable(s_reg.ovf_flag) && $stable(s_reg.ovr_flag);
   endsequence
   sequence s_status_write;
      psel && !penable && pwrite && paddr == OFS_STATUS;
   endsequence

   property p_status_run;
      s_status_read |=> prdata[ST_ACQ_ACTIVE] == $past(acq_active) && prdata[31:16] == 16'h0000;
   endproperty
   a_status_run: assert property (p_status_run) else $error("status run bit wrong"); // RULE1
   property p_tc_set;
      xfer_tc |=> xfer_count_done_flag && s_reg.irq_stat[IRQ_TC];
   endproperty
   a_tc_set: assert property (p_tc_set) else $error("terminal-count flag not set"); // RULE2
   property p_tc_hold;
      xfer_count_done_flag && !tc_clr |=> xfer_count_done_flag;
   endproperty
   a_tc_hold: assert property (p_tc_hold) else $error("terminal-count flag lost"); // RULE3
   property p_tc_clear;
      tc_clr && !xfer_tc |=> !xfer_count_done_flag;
   endproperty
   a_tc_clear: assert property (p_tc_clear) else $error("terminal-count clear ignored"); // RULE3
   property p_ovf_set;
      ovf_evt |=> s_reg.ovf_flag;
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set"); // RULE4
   property p_ovf_abort;
      ovf_evt && acq_active |=> !acq_active && acq_abort ##1 !acq_abort;
   endproperty
   a_ovf_abort: assert property (p_ovf_abort) else $error("overflow did not end run"); // RULE5
   property p_ovr_set;
      ovr_evt |=> s_reg.ovr_flag;
   endproperty
   a_ovr_set: assert property (p_ovr_set) else $error("overrun flag not set"); // RULE6
   property p_ovr_abort;
      ovr_evt && acq_active |=> !acq_active;
   endproperty
   a_ovr_abort: assert property (p_ovr_abort) else $error("overrun did not end run"); // RULE7
   property p_conv_clear;
      conv_clr && !ovf_evt && !ovr_evt |=> !s_reg.ovf_flag && !s_reg.ovr_flag;
   endproperty
   a_conv_clear: assert property (p_conv_clear) else $error("conversion clear ignored"); // RULE8
   property p_gain_read;
      s_status_read |=> prdata[ST_GAIN_LSB +: 2] == $past(gain_code);
   endproperty
   a_gain_read: assert property (p_gain_read) else $error("gain readback wrong"); // RULE9
   property p_dual_toggle;
      s_reg.dual && xfer_done |=> xfer_channel_sel != $past(xfer_channel_sel);
   endproperty
   a_dual_toggle: assert property (p_dual_toggle) else $error("dual channel did not alternate"); // RULE10
   property p_single_ch;
      !s_reg.dual |=> !xfer_channel_sel;
   endproperty
   a_single_ch: assert property (p_single_ch) else $error("channel 2 used without dual mode"); // RULE11
   property p_read_quiet;
      (s_status_read and (!xfer_tc && !ovf_evt && !ovr_evt && !wr)) ##1 !xfer_tc && !ovf_evt && !ovr_evt && !wr
         |=> s_flags_kept;
   endproperty
   a_read_quiet: assert property (p_read_quiet) else $error("status read disturbed a flag"); // RULE18
   property p_run_start;
      !acq_active && acq_start && !ovf_evt && !ovr_evt |=> acq_active;
   endproperty
   a_run_start: assert property (p_run_start) else $error("run did not start"); // RULE1
   property p_run_keep;
      acq_active && !acq_count_done && !ovf_evt && !ovr_evt |=> acq_active;
   endproperty
   a_run_keep: assert property (p_run_keep) else $error("run ended without cause"); // RULE1
   property p_run_done;
      acq_active && acq_count_done && !ovf_evt && !ovr_evt |=> !acq_active && !acq_abort;
   endproperty
   a_run_done: assert property (p_run_done) else $error("normal run end wrong"); // RULE1
   property p_idle_abort;
      (ovf_evt || ovr_evt) && !acq_active |=> !acq_abort;
   endproperty
   a_idle_abort: assert property (p_idle_abort) else $error("abort without a run"); // RULE5 RULE7
   property p_abort_once;
      acq_abort |=> !acq_abort;
   endproperty
   a_abort_once: assert property (p_abort_once) else $error("abort longer than one cycle"); // RULE5 RULE7
   // Readback checks look one cycle after the setup capture, where prdata stands
   property p_tc_read;
      s_status_read |=> prdata[ST_TC_FLAG] == $past(xfer_count_done_flag);
   endproperty
   a_tc_read: assert property (p_tc_read) else $error("terminal-count bit readback wrong"); // RULE2
   property p_err_read;
      s_status_read |=> prdata[ST_OVERFLOW] == $past(s_reg.ovf_flag) && prdata[ST_OVERRUN] == $past(s_reg.ovr_flag);
   endproperty
   a_err_read: assert property (p_err_read) else $error("error bit readback wrong"); // RULE4 RULE6
   property p_ch_read;
      s_status_read |=> prdata[ST_XFER_CH] == $past(xfer_channel_sel);
   endproperty
   a_ch_read: assert property (p_ch_read) else $error("channel bit readback wrong"); // RULE10
   property p_mux_read;
      s_status_read |=> prdata[ST_UPPER_MUX] == $past(upper_mux_on) && prdata[ST_LOWER_MUX] == $past(lower_mux_on);
   endproperty
   a_mux_read: assert property (p_mux_read) else $error("mux enable readback wrong"); // RULE12 RULE13
   property p_addr_read;
      s_status_read |=> prdata[ST_ADDR_LSB +: 3] == $past(mux_addr_low);
   endproperty
   a_addr_read: assert property (p_addr_read) else $error("mux address readback wrong"); // RULE14
   property p_status_ro;
      s_status_write ##1 penable |-> pslverr;
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status write not refused"); // RULE17
endmodule
`default_nettype wire

// >>> acq_status_pkg.sv
// Constants and types shared by the acquisition status block
package acq_status_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_TC_CLEAR = 8'h08;
   localparam logic [7:0] OFS_CONV_CLEAR = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   // Status word bit positions
   localparam int ST_ACQ_ACTIVE = 11;
   localparam int ST_TC_FLAG = 10;
   localparam int ST_OVERFLOW = 9;
   localparam int ST_OVERRUN = 8;
   localparam int ST_GAIN_LSB = 6;
   localparam int ST_XFER_CH = 5;
   localparam int ST_UPPER_MUX = 4;
   localparam int ST_LOWER_MUX = 3;
   localparam int ST_ADDR_LSB = 0;
   // Control register fields
   localparam int CT_CHAN_LSB = 0;
   localparam int CT_GAIN_LSB = 4;
   localparam int CT_DUAL = 6;
   localparam int CT_DIFF = 7;
   // Interrupt status and mask bits
   localparam int IRQ_TC = 0;
   localparam int IRQ_OVERFLOW = 1;
   localparam int IRQ_OVERRUN = 2;
   localparam int IRQ_ACQ_END = 3;
   localparam int IRQ_W = 4;
   localparam logic [3:0] RST_IRQ_MASK = 4'h0;
   localparam logic [3:0] RST_CHAN = 4'h0;
   localparam logic [1:0] RST_GAIN = 2'h0;
   localparam logic [31:0] RST_RDATA = 32'h0000_0000;
   localparam logic [2:0] LOW_CHAN_MASK = 3'h7;
   typedef enum logic {ACQ_IDLE, ACQ_RUN} acq_state_type;
endpackage

// >>> mux_sel_if.sv
// Channel selection signals between status core and mux decoder
`timescale 1ns/100ps
`default_nettype none
interface mux_sel_if;
   logic [3:0] chan;
   logic diff;
   logic upper_mux_on;
   logic lower_mux_on;
   logic [2:0] mux_addr_low;
   modport ctl (output chan, output diff, input upper_mux_on, input lower_mux_on, input mux_addr_low);
   modport dec (input chan, input diff, output upper_mux_on, output lower_mux_on, output mux_addr_low);
endinterface
`default_nettype wire

// >>> mux_decode.sv
// Input multiplexer enable and address decoder
`timescale 1ns/100ps
`default_nettype none
module mux_decode
   import acq_status_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   mux_sel_if.dec sel
);
   typedef struct packed {
      logic upper;
      logic lower;
      logic [2:0] addr;
   } dec_state_type;

   dec_state_type s_reg;
   dec_state_type s_next;

   always_comb begin
      s_next = s_reg;
      s_next.addr = sel.chan[2:0] & LOW_CHAN_MASK; // RULE14 RULE15
      if (sel.diff) begin
         // Both muxes stay on so the pair addr and addr+8 is selected
         s_next.upper = 1'b1; // RULE16 RULE15
         s_next.lower = 1'b1; // RULE16
      end else begin
         s_next.upper = sel.chan[3]; // RULE12
         s_next.lower = ~sel.chan[3]; // RULE13
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign sel.upper_mux_on = s_reg.upper;
   assign sel.lower_mux_on = s_reg.lower;
   assign sel.mux_addr_low = s_reg.addr;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   property p_diff_both;
      sel.diff |=> sel.upper_mux_on && sel.lower_mux_on;
   endproperty
   a_diff_both: assert property (p_diff_both) else $error("diff mode lost a mux enable"); // RULE16
   property p_single_upper;
      !sel.diff |=> sel.upper_mux_on == $past(sel.chan[3]) && sel.lower_mux_on != sel.upper_mux_on;
   endproperty
   a_single_upper: assert property (p_single_upper) else $error("single-ended mux enable wrong"); // RULE12
   property p_addr_low;
      1'b1 |=> sel.mux_addr_low == $past(sel.chan[2:0]);
   endproperty
   a_addr_low: assert property (p_addr_low) else $error("mux address low bits wrong"); // RULE14
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking testbench for the acquisition status block
`timescale 1ns/100ps
`default_nettype none
module tb;
   import acq_status_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [5:0] pl = '0;
   logic conv_busy = 1'b0;
   logic fifo_full = 1'b0;
   logic acq_active;
   logic acq_abort;
   logic xfer_count_done_flag;
   logic xfer_channel_sel;
   logic [1:0] gain_code;
   logic upper_mux_on;
   logic lower_mux_on;
   logic [2:0] mux_addr_low;
   logic irq;
   logic [31:0] rdata;
   logic err;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;

   acq_status i_acq_status (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .acq_start(pl[0]), .acq_count_done(pl[1]), .xfer_tc(pl[2]), .xfer_done(pl[3]), .conv_start(pl[4]),
      .conv_busy(conv_busy), .conv_result_valid(pl[5]), .fifo_full(fifo_full), .acq_active(acq_active),
      .acq_abort(acq_abort), .xfer_count_done_flag(xfer_count_done_flag), .xfer_channel_sel(xfer_channel_sel),
      .gain_code(gain_code), .upper_mux_on(upper_mux_on), .lower_mux_on(lower_mux_on),
      .mux_addr_low(mux_addr_low), .irq(irq));

   always #12.5 clk_sys = ~clk_sys;

   task automatic stop_test;
      if (n_fail == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Ceiling well above the roughly 140 cycles the sequence needs
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         stop_test;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, seen, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(rdata, exp, "read data");
   endtask

   // One-cycle event pulse; returns at the edge that samples it, then lets updates land
   task automatic pulse(input logic [5:0] m);
      @(posedge clk_sys);
      pl <= m;
      @(posedge clk_sys);
      pl <= '0;
      #1;
   endtask

   initial begin
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rd(OFS_STATUS, 32'h0000_0008);
      check(irq, 1'b0, "irq after reset");
      // Channel 11, gain 2, single-ended
      wr(OFS_CTRL, 32'h0000_002B);
      rd(OFS_STATUS, 32'h0000_0093);
      check(gain_code, 2'h2, "gain");
      wr(OFS_CTRL, 32'h0000_0085);
      rd(OFS_STATUS, 32'h0000_001D);
      check({upper_mux_on, lower_mux_on, mux_addr_low}, 5'b11101, "diff mux pins");
      wr(OFS_CTRL, 32'h0000_0007);
      rd(OFS_STATUS, 32'h0000_000F);
      // Status is read-only; unmapped place refused
      wr(OFS_STATUS, 32'h0000_FFFF);
      check(err, 1'b1, "status write error");
      rd(OFS_STATUS, 32'h0000_000F);
      rd(8'h20, 32'h0000_0000);
      check(err, 1'b1, "unmapped error");
      // Conversion start while idle converter is no overrun
      pulse(6'h10);
      rd(OFS_STATUS, 32'h0000_000F);
      // Overflow aborts a run
      pulse(6'h01);
      check(acq_active, 1'b1, "run started");
      rd(OFS_STATUS, 32'h0000_080F);
      fifo_full <= 1'b1;
      pulse(6'h20);
      check({acq_active, acq_abort}, 2'b01, "overflow abort");
      @(posedge clk_sys);
      fifo_full <= 1'b0;
      rd(OFS_STATUS, 32'h0000_020F);
      rd(OFS_STATUS, 32'h0000_020F);
      check(irq, 1'b0, "masked irq");
      wr(OFS_IRQ_MASK, 32'h0000_0002);
      @(negedge clk_sys);
      check(irq, 1'b1, "overflow irq");
      wr(OFS_IRQ_STATUS, 32'h0000_0002);
      @(negedge clk_sys);
      check(irq, 1'b0, "irq cleared");
      wr(OFS_CONV_CLEAR, 32'h0000_0001);
      rd(OFS_STATUS, 32'h0000_000F);
      // Overrun aborts a run
      pulse(6'h01);
      @(posedge clk_sys);
      conv_busy <= 1'b1;
      pulse(6'h10);
      check({acq_active, acq_abort}, 2'b01, "overrun abort");
      @(posedge clk_sys);
      conv_busy <= 1'b0;
      rd(OFS_STATUS, 32'h0000_010F);
      wr(OFS_CONV_CLEAR, 32'h0000_0001);
      rd(OFS_STATUS, 32'h0000_000F);
      // Terminal count flag, its interrupt and its own clear strobe
      wr(OFS_IRQ_MASK, 32'h0000_0001);
      pulse(6'h04);
      check({xfer_count_done_flag, irq}, 2'b11, "tc flag");
      rd(OFS_STATUS, 32'h0000_040F);
      wr(OFS_CONV_CLEAR, 32'h0000_0001);
      rd(OFS_STATUS, 32'h0000_040F);
      wr(OFS_TC_CLEAR, 32'h0000_0001);
      rd(OFS_STATUS, 32'h0000_000F);
      wr(OFS_IRQ_STATUS, 32'h0000_0001);
      @(negedge clk_sys);
      check(irq, 1'b0, "tc irq cleared");
      // Dual transfer mode alternates channels
      wr(OFS_CTRL, 32'h0000_0047);
      pulse(6'h08);
      check(xfer_channel_sel, 1'b1, "second channel");
      rd(OFS_STATUS, 32'h0000_002F);
      pulse(6'h08);
      check(xfer_channel_sel, 1'b0, "first channel");
      pulse(6'h08);
      wr(OFS_CTRL, 32'h0000_0007);
      // Channel bit is forced one cycle after the mode bit lands
      @(posedge clk_sys);
      @(negedge clk_sys);
      check(xfer_channel_sel, 1'b0, "single mode");
      pulse(6'h08);
      rd(OFS_STATUS, 32'h0000_000F);
      // Normal end of a run leaves no abort
      pulse(6'h01);
      pulse(6'h02);
      check({acq_active, acq_abort}, 2'b00, "normal end");
      rd(OFS_STATUS, 32'h0000_000F);
      stop_test;
   end
endmodule
`default_nettype wire
